/* verilog/timer_pkg.sv */
// constants, register map and types of the two channel capture/compare timer
package timer_pkg;

	// ==========================================================
	// widths
	localparam int unsigned DATA_W  = 32;
	localparam int unsigned ADDR_W  = 8;
	localparam int unsigned CNT_W   = 16;
	localparam int unsigned BYTE_W  = 8;
	localparam int unsigned CH_NUM  = 2;

	// ==========================================================
	// register byte addresses
	localparam logic [7:0] ADDR_CTRL     = 8'h00;
	localparam logic [7:0] ADDR_COUNT    = 8'h04;
	localparam logic [7:0] ADDR_MOD_HIGH = 8'h08;
	localparam logic [7:0] ADDR_MOD_LOW  = 8'h0c;
	localparam logic [7:0] ADDR_CH0_SC   = 8'h10;
	localparam logic [7:0] ADDR_CH0_VAL  = 8'h14;
	localparam logic [7:0] CH_STRIDE     = 8'h08;

	// ==========================================================
	// field positions
	localparam int unsigned CTRL_STOP = 5;
	localparam int unsigned CTRL_RST  = 4;
	localparam int unsigned SC_FLAG  = 7;
	localparam int unsigned SC_IE    = 6;
	localparam int unsigned SC_MSB   = 5;
	localparam int unsigned SC_MSA   = 4;
	localparam int unsigned SC_ELSB  = 3;
	localparam int unsigned SC_ELSA  = 2;
	localparam int unsigned SC_TOV   = 1;

	// ==========================================================
	// reset values and edge/level select codes
	localparam logic [15:0] COUNT_RESET  = 16'h0000;
	localparam logic [15:0] MOD_RESET    = 16'hffff;
	localparam logic [15:0] VAL_RESET    = 16'h0000;
	localparam logic        STOP_RESET   = 1'b1;
	localparam logic [31:0] RDATA_RESET  = 32'h0000_0000;
	localparam logic [1:0]  ELS_NONE     = 2'b00;
	localparam logic [1:0]  ELS_TOGGLE   = 2'b01;
	localparam logic [1:0]  ELS_CLEAR    = 2'b10;
	localparam logic [1:0]  ELS_SET      = 2'b11;

	// ==========================================================
	// channel function
	typedef enum logic [1:0] {
		MODE_PRESET,
		MODE_CAPTURE,
		MODE_COMPARE
	} chan_mode_t;

endpackage : timer_pkg

/* verilog/timer_channel.sv */
// one timer channel: edge capture, compare match and pin output
`timescale 1ns/1ps
module timer_channel (
	input  wire logic        i_clock,
	input  wire logic        i_rst_b,
	input  wire logic        i_enable,
	input  wire logic        i_buffered,
	input  wire logic        i_mode_select_a,
	input  wire logic [1:0]  i_edge_level,
	input  wire logic        i_toggle_on_overflow,
	input  wire logic        i_tick,
	input  wire logic        i_overflow,
	input  wire logic [15:0] i_count,
	input  wire logic [15:0] i_compare,
	input  wire logic        i_pin,
	output logic             o_event,
	output logic             o_capture,
	output logic             o_level,
	output logic             o_drive
);

	// ==========================================================
	// state
	typedef struct packed {
		logic prev_pin;
		logic level;
		logic drive;
	} chan_state_t;

	chan_state_t          s_reg;
	chan_state_t          s_next;
	timer_pkg::chan_mode_t mode;
	logic                 is_compare;
	logic                 match;
	logic                 rise;
	logic                 fall;

	assign o_level = s_reg.level;
	assign o_drive = s_reg.drive;

	// ==========================================================
	// behaviour
	always_comb begin
		s_next     = s_reg;
		is_compare = i_buffered | i_mode_select_a;
		if (i_edge_level == timer_pkg::ELS_NONE) begin
			mode = timer_pkg::MODE_PRESET;
		end else if (is_compare) begin
			mode = timer_pkg::MODE_COMPARE;
		end else begin
			mode = timer_pkg::MODE_CAPTURE;
		end
		match = i_tick && (i_count == i_compare);
		rise  = i_pin & ~s_reg.prev_pin;
		fall  = ~i_pin & s_reg.prev_pin;
		s_next.prev_pin = i_pin;
		o_event   = 1'b0;
		o_capture = 1'b0;
		case (mode)
			timer_pkg::MODE_CAPTURE: begin
				// rising with low bit, falling with high bit
				o_capture = (i_edge_level[0] & rise) |
					(i_edge_level[1] & fall);
				o_event   = i_enable & o_capture;
			end
			timer_pkg::MODE_COMPARE: begin
				o_event = i_enable & match;
				if (i_toggle_on_overflow && i_overflow) begin
					s_next.level = ~s_reg.level;
				end else if (match) begin
					case (i_edge_level)
						timer_pkg::ELS_TOGGLE: s_next.level = ~s_reg.level;
						timer_pkg::ELS_CLEAR:  s_next.level = 1'b0;
						timer_pkg::ELS_SET:    s_next.level = 1'b1;
						default:               s_next.level = s_reg.level;
					endcase
				end
			end
			timer_pkg::MODE_PRESET: begin
				s_next.level = ~i_mode_select_a;
				o_event      = i_enable & is_compare & match;
			end
			default: begin
				s_next.level = s_reg.level;
			end
		endcase
		// pin only driven in compare mode with an action selected
		s_next.drive = i_enable && (mode == timer_pkg::MODE_COMPARE);
	end

	always_ff @(posedge i_clock) begin
		if (!i_rst_b) begin
			s_reg <= '0;
		end else begin
			s_reg <= s_next;
		end
	end

endmodule : timer_channel

/* verilog/capture_compare_timer.sv */
// two channel capture/compare timer with apb register access
`timescale 1ns/1ps
// Function
// - 16-bit counter, free or modulo, shared
// - counter reads never disturb counting
// - each channel capture or compare independently
// - capture edge sets channel event flag
// - counter equals compare value sets flag
// - flag clears by read-set then zero write
// - new event between read and write kept
// - writing one ignored, reset clears flag
// - per channel interrupt enable, reset clear
// - buffered select only on channel zero
// - buffered mode disables channel one
// - mode a picks capture or compare
// - edge bits zero: mode a presets level
// - capture edge: rising, falling or both
// - compare action: none, toggle, low, high
// - buffered mode: toggle, clear or set
// - edge bits zero releases the pin
// - reset clears edge, mode a, toggle bits
// - toggle on overflow in compare only
// - overflow beats compare in same cycle
module capture_compare_timer (
	input  wire logic        i_clock,
	input  wire logic        i_rst_b,
	input  wire logic        i_psel,
	input  wire logic        i_penable,
	input  wire logic        i_pwrite,
	input  wire logic [7:0]  i_paddr,
	input  wire logic [31:0] i_pwdata,
	input  wire logic [1:0]  i_channel_pin,
	output logic      [31:0] o_prdata,
	output logic             o_pready,
	output logic             o_pslverr,
	output logic      [1:0]  o_channel_pin,
	output logic      [1:0]  o_channel_pin_oe,
	output logic      [1:0]  o_channel_irq
);

	// ==========================================================
	// state
	typedef struct packed {
		logic        channel_event_flag;
		logic        channel_irq_enable;
		logic        mode_select_a;
		logic        edge_level_b;
		logic        edge_level_a;
		logic        toggle_on_overflow;
		logic        clear_armed;
		logic [15:0] value;
	} chan_reg_t;

	typedef struct packed {
		logic [15:0]    count;
		logic [15:0]    modulo;
		logic           counter_stop_bit;
		logic           chan0_buffered_select;
		logic [15:0]    buffer_active;
		logic           buffer_from_chan1;
		chan_reg_t [1:0] ch;
		logic [31:0]    prdata;
		logic           pready;
		logic           pslverr;
		logic [1:0]     irq;
	} timer_state_t;

	timer_state_t s_reg;
	timer_state_t s_next;

	logic        tick;
	logic        overflow;
	logic        setup;
	logic        access;
	logic        wr;
	logic        rd;
	logic [1:0]  chan_event;
	logic [1:0]  chan_capture;
	logic [1:0]  chan_level;
	logic [1:0]  chan_drive;
	logic [1:0]  chan_enable;
	logic [15:0] chan_compare [0:1];
	logic [7:0]  sc_addr [0:1];
	logic [7:0]  val_addr [0:1];

	assign o_prdata  = s_reg.prdata;
	assign o_pready  = s_reg.pready;
	assign o_pslverr = s_reg.pslverr;
	assign o_channel_irq = s_reg.irq;

	// ==========================================================
	// channels
	genvar gi;
	generate
		for (gi = 0; gi < timer_pkg::CH_NUM; gi++) begin : g_chan
			assign sc_addr[gi] = 8'(timer_pkg::ADDR_CH0_SC +
				timer_pkg::CH_STRIDE * 8'(gi));
			assign val_addr[gi] = 8'(timer_pkg::ADDR_CH0_VAL +
				timer_pkg::CH_STRIDE * 8'(gi));
			// buffered channel zero uses the shadowed compare value
			assign chan_compare[gi] = (gi == 0 && s_reg.chan0_buffered_select)
				? s_reg.buffer_active : s_reg.ch[gi].value;
			// channel one is switched off in buffered mode
			assign chan_enable[gi] = (gi == 0) ? 1'b1 :
				~s_reg.chan0_buffered_select;
			assign o_channel_pin[gi]    = chan_level[gi];
			assign o_channel_pin_oe[gi] = chan_drive[gi];

			timer_channel u_channel (
				.i_clock              (i_clock),
				.i_rst_b              (i_rst_b),
				.i_enable             (chan_enable[gi]),
				.i_buffered           ((gi == 0) &&
					s_reg.chan0_buffered_select),
				.i_mode_select_a      (s_reg.ch[gi].mode_select_a),
				.i_edge_level         ({s_reg.ch[gi].edge_level_b,
					s_reg.ch[gi].edge_level_a}),
				.i_toggle_on_overflow (s_reg.ch[gi].toggle_on_overflow),
				.i_tick               (tick),
				.i_overflow           (overflow),
				.i_count              (s_reg.count),
				.i_compare            (chan_compare[gi]),
				.i_pin                (i_channel_pin[gi]),
				.o_event              (chan_event[gi]),
				.o_capture            (chan_capture[gi]),
				.o_level              (chan_level[gi]),
				.o_drive              (chan_drive[gi])
			);
		end
	endgenerate

	// ==========================================================
	// read data
	function automatic logic [31:0] status_word(
		input chan_reg_t c,
		input logic      buffered
	);
		logic [31:0] w;
		w = '0;
		w[timer_pkg::SC_FLAG] = c.channel_event_flag;
		w[timer_pkg::SC_IE]   = c.channel_irq_enable;
		w[timer_pkg::SC_MSB]  = buffered;
		w[timer_pkg::SC_MSA]  = c.mode_select_a;
		w[timer_pkg::SC_ELSB] = c.edge_level_b;
		w[timer_pkg::SC_ELSA] = c.edge_level_a;
		w[timer_pkg::SC_TOV]  = c.toggle_on_overflow;
		return w;
	endfunction : status_word

	// ==========================================================
	// next state
	always_comb begin
		s_next   = s_reg;
		setup    = i_psel & ~i_penable;
		access   = i_psel & i_penable & s_reg.pready;
		wr       = access & i_pwrite;
		rd       = access & ~i_pwrite;
		tick     = ~s_reg.counter_stop_bit;
		overflow = tick && (s_reg.count == s_reg.modulo);

		// counter, wraps at the modulo value
		if (tick) begin
			s_next.count = overflow ? timer_pkg::COUNT_RESET :
				16'(s_reg.count + 16'h0001);
		end
		// buffered compare shadow reloads at overflow
		if (overflow || !s_reg.chan0_buffered_select) begin
			s_next.buffer_active = s_reg.buffer_from_chan1 ?
				s_reg.ch[1].value : s_reg.ch[0].value;
		end

		// apb: one access phase, answer registered at setup
		s_next.pready  = setup;
		s_next.pslverr = 1'b0;
		if (setup) begin
			s_next.pslverr = 1'b0;
			s_next.prdata  = timer_pkg::RDATA_RESET;
			case (i_paddr)
				timer_pkg::ADDR_CTRL:
					s_next.prdata[timer_pkg::CTRL_STOP] =
						s_reg.counter_stop_bit;
				timer_pkg::ADDR_COUNT:
					s_next.prdata[15:0] = s_reg.count;
				timer_pkg::ADDR_MOD_HIGH:
					s_next.prdata[7:0] = s_reg.modulo[15:8];
				timer_pkg::ADDR_MOD_LOW:
					s_next.prdata[7:0] = s_reg.modulo[7:0];
				sc_addr[0]:
					s_next.prdata = status_word(s_reg.ch[0],
						s_reg.chan0_buffered_select);
				val_addr[0]:
					s_next.prdata[15:0] = s_reg.ch[0].value;
				sc_addr[1]:
					s_next.prdata = status_word(s_reg.ch[1], 1'b0);
				val_addr[1]:
					s_next.prdata[15:0] = s_reg.ch[1].value;
				default:
					s_next.pslverr = 1'b1;
			endcase
		end

		// timer control writes
		if (wr && i_paddr == timer_pkg::ADDR_CTRL) begin
			s_next.counter_stop_bit = i_pwdata[timer_pkg::CTRL_STOP];
			if (i_pwdata[timer_pkg::CTRL_RST]) begin
				s_next.count = timer_pkg::COUNT_RESET;
			end
		end
		if (wr && i_paddr == timer_pkg::ADDR_MOD_HIGH) begin
			s_next.modulo[15:8] = i_pwdata[7:0];
		end
		if (wr && i_paddr == timer_pkg::ADDR_MOD_LOW) begin
			s_next.modulo[7:0] = i_pwdata[7:0];
		end
		if (wr && i_paddr == sc_addr[0]) begin
			s_next.chan0_buffered_select =
				i_pwdata[timer_pkg::SC_MSB];
		end

		// per channel registers
		for (int i = 0; i < timer_pkg::CH_NUM; i++) begin
			// reading the status with the flag set arms the clear
			if (rd && i_paddr == sc_addr[i] &&
				s_reg.prdata[timer_pkg::SC_FLAG]) begin
				s_next.ch[i].clear_armed = 1'b1;
			end
			if (wr && i_paddr == sc_addr[i] && chan_enable[i]) begin
				s_next.ch[i].channel_irq_enable =
					i_pwdata[timer_pkg::SC_IE];
				s_next.ch[i].mode_select_a =
					i_pwdata[timer_pkg::SC_MSA];
				s_next.ch[i].edge_level_b =
					i_pwdata[timer_pkg::SC_ELSB];
				s_next.ch[i].edge_level_a =
					i_pwdata[timer_pkg::SC_ELSA];
				s_next.ch[i].toggle_on_overflow =
					i_pwdata[timer_pkg::SC_TOV];
				// only a zero write after an armed read clears
				if (!i_pwdata[timer_pkg::SC_FLAG] &&
					s_reg.ch[i].clear_armed) begin
					s_next.ch[i].channel_event_flag = 1'b0;
				end
				s_next.ch[i].clear_armed = 1'b0;
			end
			if (wr && i_paddr == val_addr[i]) begin
				s_next.ch[i].value = i_pwdata[15:0];
				s_next.buffer_from_chan1 = (i == 1);
			end
			// a new event sets the flag and cancels a pending clear
			if (chan_event[i]) begin
				s_next.ch[i].channel_event_flag = 1'b1;
				s_next.ch[i].clear_armed        = 1'b0;
			end
			if (chan_capture[i] && chan_enable[i]) begin
				s_next.ch[i].value = s_reg.count;
			end
			s_next.irq[i] = s_next.ch[i].channel_event_flag &
				s_next.ch[i].channel_irq_enable;
		end
	end

	// ==========================================================
	// registers
	always_ff @(posedge i_clock) begin
		if (!i_rst_b) begin
			s_reg                  <= '0;
			s_reg.count            <= timer_pkg::COUNT_RESET;
			s_reg.modulo           <= timer_pkg::MOD_RESET;
			s_reg.counter_stop_bit <= timer_pkg::STOP_RESET;
			s_reg.buffer_active    <= timer_pkg::VAL_RESET;
			s_reg.prdata           <= timer_pkg::RDATA_RESET;
		end else begin
			s_reg <= s_next;
		end
	end

endmodule : capture_compare_timer

/* testbench/timer_properties.sv */
// port assertions for the capture/compare timer
`timescale 1ns/1ps
module timer_properties (
	input wire logic        i_clock,
	input wire logic        i_rst_b,
	input wire logic        i_psel,
	input wire logic        i_penable,
	input wire logic        i_pwrite,
	input wire logic [7:0]  i_paddr,
	input wire logic [31:0] i_pwdata,
	input wire logic [1:0]  i_channel_pin,
	input wire logic [31:0] o_prdata,
	input wire logic        o_pready,
	input wire logic        o_pslverr,
	input wire logic [1:0]  o_channel_pin,
	input wire logic [1:0]  o_channel_pin_oe,
	input wire logic [1:0]  o_channel_irq
);
	// ==========================================================
	// cycles since the last completed write, saturating at 3
	logic [1:0] age_reg;
	always_ff @(posedge i_clock) begin
		if (!i_rst_b || (i_psel && i_penable && i_pwrite && o_pready))
			age_reg <= 2'h0;
		else if (age_reg != 2'h3)
			age_reg <= age_reg + 2'h1;
	end

	// ==========================================================
	// properties
	default clocking cb @(posedge i_clock); endclocking
	default disable iff (!i_rst_b);
	property p_zero_wait;
		i_psel && i_penable |-> o_pready;
	endproperty
	a_zero_wait : assert property (p_zero_wait)
		else $error("pready missing in access cycle");
	property p_ready_access;
		o_pready |-> i_psel && i_penable;
	endproperty
	a_ready_access : assert property (p_ready_access)
		else $error("pready outside access cycle");
	property p_err_ready;
		o_pslverr |-> o_pready && o_prdata == 32'h0;
	endproperty
	a_err_ready : assert property (p_err_ready)
		else $error("pslverr without pready or with data");
	property p_mapped_ok;
		i_psel && !i_penable && i_paddr < 8'h20 && i_paddr[1:0] == 2'h0
			##1 o_pready |-> !o_pslverr;
	endproperty
	a_mapped_ok : assert property (p_mapped_ok)
		else $error("pslverr on a mapped address");
	property p_data_stands;
		o_pready ##1 !(i_psel && !i_penable) |-> $stable(o_prdata);
	endproperty
	a_data_stands : assert property (p_data_stands)
		else $error("read data changed before next setup");
	property p_irq_fall;
		|($past(o_channel_irq) & ~o_channel_irq)
			|-> $past(i_psel && i_penable && i_pwrite);
	endproperty
	a_irq_fall : assert property (p_irq_fall)
		else $error("irq dropped without a write");
	property p_reset_quiet;
		$rose(i_rst_b) |-> o_channel_irq == 2'h0 && o_channel_pin_oe == 2'h0;
	endproperty
	a_reset_quiet : assert property (p_reset_quiet)
		else $error("irq or pin enable active out of reset");
	property p_oe_cause;
		$changed(o_channel_pin_oe) |-> age_reg != 2'h3;
	endproperty
	a_oe_cause : assert property (p_oe_cause)
		else $error("pin enable changed without a write");
endmodule : timer_properties

bind capture_compare_timer timer_properties u_props (
	.i_clock(i_clock), .i_rst_b(i_rst_b), .i_psel(i_psel),
	.i_penable(i_penable), .i_pwrite(i_pwrite), .i_paddr(i_paddr),
	.i_pwdata(i_pwdata), .i_channel_pin(i_channel_pin),
	.o_prdata(o_prdata), .o_pready(o_pready), .o_pslverr(o_pslverr),
	.o_channel_pin(o_channel_pin), .o_channel_pin_oe(o_channel_pin_oe),
	.o_channel_irq(o_channel_irq)
);

/* testbench/pin_source.sv */
// external signal source on the two channel pins
`timescale 1ns/1ps
module pin_source (
	input  wire logic       i_clock,
	output logic      [1:0] o_level
);
	initial o_level = 2'h0;

	// ==========================================================
	// level change just after a clock edge
	task automatic drive(input int ch, input logic v);
		@(posedge i_clock);
		o_level[ch] <= v;
	endtask : drive
endmodule : pin_source

/* testbench/capture_compare_timer_tb.sv */
// self-checking bench for the capture/compare timer
`timescale 1ns/1ps
module capture_compare_timer_tb;
	localparam logic [7:0] CH1_SC  = timer_pkg::ADDR_CH0_SC + 8'h08;
	localparam logic [7:0] CH0_SC  = timer_pkg::ADDR_CH0_SC;
	localparam logic [7:0] CTRL    = timer_pkg::ADDR_CTRL;
	logic        clock   = 1'b0;
	logic        rst_b   = 1'b0;
	logic        psel    = 1'b0;
	logic        penable = 1'b0;
	logic        pwrite  = 1'b0;
	logic [7:0]  paddr   = 8'h00;
	logic [31:0] pwdata  = 32'h0;
	logic [31:0] prdata;
	logic        pready;
	logic        pslverr;
	logic [1:0]  pin_out;
	logic [1:0]  pin_oe;
	logic [1:0]  irq;
	logic [1:0]  ext;
	logic [1:0]  pin_wire;
	logic [31:0] rd;
	logic [31:0] c;
	logic        p;
	int          n_fail  = 0;
	int          checked = 0;

	always #50 clock = ~clock;
	// wire level from both drivers
	assign pin_wire = (pin_oe & pin_out) | (~pin_oe & ext);

	capture_compare_timer dut (
		.i_clock(clock), .i_rst_b(rst_b), .i_psel(psel),
		.i_penable(penable), .i_pwrite(pwrite), .i_paddr(paddr),
		.i_pwdata(pwdata), .i_channel_pin(pin_wire), .o_prdata(prdata),
		.o_pready(pready), .o_pslverr(pslverr), .o_channel_pin(pin_out),
		.o_channel_pin_oe(pin_oe), .o_channel_irq(irq)
	);
	pin_source u_src (
		.i_clock(clock),
		.o_level(ext)
	);

	// ==========================================================
	// tasks
	task automatic check(input string nm, input logic [31:0] s, e);
		checked++;
		if (s !== e) begin
			n_fail++;
			$display("[ERR] %s expected %h seen %h", nm, e, s);
		end
	endtask : check
	task automatic xfer(input logic w, input logic [7:0] a,
		input logic [31:0] d);
		@(posedge clock);
		psel    <= 1'b1;
		pwrite  <= w;
		paddr   <= a;
		pwdata  <= d;
		@(posedge clock);
		penable <= 1'b1;
		do @(posedge clock); while (pready !== 1'b1);
		rd = prdata;
		p = pslverr;
		psel    <= 1'b0;
		penable <= 1'b0;
	endtask : xfer
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		xfer(1'b1, a, d);
	endtask : wr
	task automatic rdchk(input string nm, input logic [7:0] a,
		input logic [31:0] e);
		xfer(1'b0, a, 32'h0);
		check(nm, rd, e);
	endtask : rdchk
	task automatic results();
		$display("checks %0d mismatches %0d", checked, n_fail);
		if (n_fail == 0 && checked > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask : results

	// ==========================================================
	// watchdog
	initial begin
		repeat (4000) @(posedge clock);
		n_fail++;
		results();
	end

	// ==========================================================
	// tests
	initial begin
		repeat (4) @(posedge clock);
		rst_b <= 1'b1;
		rdchk("ch0 status", CH0_SC, 32'h0);
		rdchk("mod high", timer_pkg::ADDR_MOD_HIGH, 32'hff);
		rdchk("unmapped", 8'h40, 32'h0);
		check("pslverr", 32'(p), 32'h1);
		$display("test reset done");
		wr(timer_pkg::ADDR_CH0_VAL, 32'h10);
		wr(CH0_SC, 32'h10);
		wr(CH0_SC, 32'h5c);
		wr(CTRL, 32'h0);
		xfer(1'b0, timer_pkg::ADDR_COUNT, 32'h0);
		c = rd;
		rdchk("count", timer_pkg::ADDR_COUNT, c + 32'h3);
		check("pin0 low", pin_wire[0], 32'h0);
		for (int i = 0; i < 100 && irq[0] !== 1'b1; i++) @(posedge clock);
		check("irq0", irq[0], 32'h1);
		check("pin0 set", pin_wire[0], 32'h1);
		wr(CH0_SC, 32'h5c);
		rdchk("flag kept", CH0_SC, 32'hdc);
		wr(CH0_SC, 32'h5c);
		rdchk("flag clear", CH0_SC, 32'h5c);
		check("irq0 low", irq[0], 32'h0);
		wr(CH0_SC, 32'hdc);
		rdchk("flag one", CH0_SC, 32'h5c);
		$display("test compare done");
		wr(CTRL, 32'h30);
		for (int m = 0; m < 2; m++) begin
			wr(CH1_SC, 32'(m << 4));
			repeat (2) @(posedge clock);
			check("preset oe", pin_oe[1], 32'h0);
			check("preset lvl", pin_out[1], 32'(m == 0));
		end
		for (int e = 1; e < 4; e++) begin
			wr(CH1_SC, 32'h40 | 32'(e << 2));
			xfer(1'b0, CH1_SC, 32'h0);
			wr(CH1_SC, 32'h40 | 32'(e << 2));
			u_src.drive(1, 1'b1);
			repeat (4) @(posedge clock);
			check("rise irq", irq[1], 32'(e & 1));
			xfer(1'b0, CH1_SC, 32'h0);
			wr(CH1_SC, 32'h40 | 32'(e << 2));
			u_src.drive(1, 1'b0);
			repeat (4) @(posedge clock);
			check("fall irq", irq[1], 32'(e >> 1));
		end
		xfer(1'b0, CH1_SC, 32'h0);
		u_src.drive(1, 1'b1);
		repeat (2) @(posedge clock);
		wr(CH1_SC, 32'h4c);
		@(posedge clock);
		check("event kept", irq[1], 32'h1);
		xfer(1'b0, CH1_SC, 32'h0);
		wr(CH1_SC, 32'h4c);
		@(posedge clock);
		check("flag cleared", irq[1], 32'h0);
		$display("test capture done");
		wr(CH1_SC, 32'h3c);
		rdchk("ch1 no buf", CH1_SC, 32'h1c);
		wr(CH0_SC, 32'h24);
		wr(CH1_SC, 32'h0);
		rdchk("ch1 locked", CH1_SC, 32'h1c);
		check("ch1 oe", pin_oe[1], 32'h0);
		$display("test buffered done");
		wr(timer_pkg::ADDR_CH0_VAL, 32'h7);
		wr(timer_pkg::ADDR_MOD_HIGH, 32'h0);
		wr(timer_pkg::ADDR_MOD_LOW, 32'h7);
		wr(CH0_SC, 32'h2e);
		wr(CTRL, 32'h10);
		p = pin_wire[0];
		for (int i = 0; i < 50 && pin_wire[0] === p; i++) @(posedge clock);
		repeat (4) @(posedge clock);
		p = pin_wire[0];
		repeat (8) @(posedge clock);
		check("ovf toggle", pin_wire[0], {31'h0, ~p});
		repeat (8) @(posedge clock);
		check("ovf again", pin_wire[0], 32'(p));
		$display("test overflow done");
		results();
	end
endmodule : capture_compare_timer_tb
